// ==== sim/indicator_lamp.sv ====
`timescale 1ns/1ps
`default_nettype none
module indicator_lamp
    import status_led_pkg::*;
(
    input wire logic [1:0] color,
    output logic green_lit,
    output logic red_lit
);
    // Bicolour lamp, both dies lit reads as yellow
    assign green_lit = color[0];
    assign red_lit = color[1];
endmodule
`default_nettype wire

// ==== sim/status_led_indicator_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module status_led_indicator_checker
    import status_led_pkg::*;
#(
    parameter int unsigned LAMP_TEST = 20
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic device_error,
    input wire logic screen_error,
    input wire logic screen_warning,
    input wire logic sleep_mode,
    input wire logic identify_request,
    input wire logic safety_output_on,
    input wire logic field_interrupted,
    input wire logic interlocked,
    input wire logic report_screen_warning,
    input wire logic report_screen_error,
    input wire logic [1:0] safety_output_indicator,
    input wire logic [1:0] device_status_indicator
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [31:0] up;
    logic [31:0] next_up;
    logic live;
    // Cycles since release, saturating so it cannot wrap
    always_comb begin
        next_up = (up > LAMP_TEST + 8) ? up : up + 32'h1;
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            up <= 32'h0;
        end else begin
            up <= next_up;
        end
    end
    // Lamp test is over with margin for the register stage
    assign live = up > LAMP_TEST + 4;
    chk_lamp_both: assert property (
        up >= 3 && up < LAMP_TEST |-> device_status_indicator == COLOR_YELLOW
        && safety_output_indicator == COLOR_YELLOW && !safety_output_on) else $error("lamp test wrong");
    chk_out_green: assert property (
        safety_output_on && $past(safety_output_on) |-> safety_output_indicator == COLOR_GREEN)
        else $error("output lamp not green");
    chk_out_red: assert property (
        live && !safety_output_on && !$past(safety_output_on) |-> safety_output_indicator == COLOR_RED)
        else $error("output lamp not red");
    chk_field_inv: assert property (field_interrupted == !safety_output_on)
        else $error("field status not inverse of output");
    chk_err_stop: assert property (
        screen_error[*4] |-> !safety_output_on && report_screen_error) else $error("screen error ignored");
    chk_warn_report: assert property (
        (screen_warning && !screen_error)[*4] |-> report_screen_warning && !report_screen_error)
        else $error("warning report wrong");
    chk_dev_latch: assert property (interlocked |=> interlocked)
        else $error("interlock dropped");
    chk_dev_set: assert property (device_error[*4] |-> interlocked)
        else $error("interlock not set");
    chk_lock_off: assert property ($past(interlocked) |-> !safety_output_on)
        else $error("output on while interlocked");
    chk_sleep_dark: assert property (
        (live && sleep_mode && !identify_request && !interlocked)[*5] |-> device_status_indicator == COLOR_OFF)
        else $error("status lamp lit in sleep");
    cover property ($rose(interlocked));
    cover property (report_screen_error);
    cover property (live && device_status_indicator == COLOR_OFF);
endmodule
`default_nettype wire

// ==== sim/tb_status_led_indicator.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_status_led_indicator;
    import status_led_pkg::*;
    typedef struct packed {logic [13:0] m; logic [1:0] a; logic [1:0] b; logic f; logic s;} case_t;
    // Inputs, two colours, fast rate, output on
    logic [19:0] tbl [15] = '{20'h002D5, 20'h022FD, 20'h082C0, 20'h102C0, 20'h202E5, 20'h012F2,
        20'h0026C, 20'h003EC, 20'h000F5, 20'h042D3, 20'h402F1, 20'h004D1, 20'h802F2, 20'h412F2, 20'h00AE0};
    logic ref_clk;
    logic reset;
    logic [13:0] stim;
    logic [1:0] sol;
    logic [1:0] dsl;
    logic so_on, fi, lk, rw, re, g_lit, r_lit;
    logic [31:0] seed = 32'h00010552;
    int num_errors = 0;
    int samples_checked = 0;
    int idx;
    status_led_indicator #(.SLOW_HALF(10), .FAST_HALF(4), .LAMP_TEST(20)) status_led_indicator_i (
        .ref_clk(ref_clk), .reset(reset), .field_request_on(stim[0]), .configured(stim[1]),
        .config_fault(stim[2]), .config_verified(stim[3]), .test_mode(stim[4]), .device_error(stim[5]),
        .recoverable_error(stim[6]), .warning_field_interrupted(stim[7]), .restart_delay_active(stim[8]),
        .sleep_mode(stim[9]), .safety_stopped(stim[10]), .identify_request(stim[11]),
        .screen_warning(stim[12]), .screen_error(stim[13]), .safety_output_on(so_on),
        .field_interrupted(fi), .interlocked(lk), .report_screen_warning(rw), .report_screen_error(re),
        .safety_output_indicator(sol), .device_status_indicator(dsl));
    indicator_lamp indicator_lamp_i (.color(dsl), .green_lit(g_lit), .red_lit(r_lit));
    // Free-running 200 MHz clock
    initial begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk_num(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic chk_color(input string n, input logic [1:0] e, input logic [1:0] g);
        chk_num(n, {6'h0, e}, {6'h0, g});
    endtask
    // Reset held three cycles, then the lamp test is let run out
    task automatic restart;
        reset = 1'h1;
        repeat (3) @(negedge ref_clk);
        reset = 1'h0;
        repeat (10) @(negedge ref_clk);
        chk_color("lamp", COLOR_YELLOW, {r_lit, g_lit});
        repeat (30) @(negedge ref_clk);
    endtask
    // Apply one condition set and score the lamp pattern over two slow periods
    task automatic run(input logic [19:0] e, input logic [13:0] m);
        case_t c;
        int hits;
        int flips;
        logic [1:0] prev;
        c = case_t'(e);
        stim = m;
        repeat (12) @(negedge ref_clk);
        hits = 0;
        flips = 0;
        prev = dsl;
        repeat (40) begin
            @(negedge ref_clk);
            hits += (dsl === c.a) + 2 * (dsl === c.b);
            flips += (dsl !== prev);
            prev = dsl;
        end
        chk_num("pattern", (c.a == c.b) ? 8'h78 : 8'h3C, 8'(hits));
        chk_num("fast", {7'h0, c.f}, {7'h0, flips > 6});
        chk_color("safe_led", (c.s & m[0]) ? COLOR_GREEN : COLOR_RED, sol);
        chk_num("report", {6'h0, m[13], m[12] & ~m[13]}, {6'h0, re, rw});
    endtask
    task automatic results;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        stim = 14'h0;
        restart();
        for (int i = 0; i < 14; i++) run(tbl[i], tbl[i][19:6]);
        // Random order with the protective field randomly interrupted
        for (int i = 0; i < 30; i++) begin
            seed = xs(seed);
            idx = seed % 14;
            run(tbl[idx], {tbl[idx][19:7], tbl[idx][6] & seed[8]});
        end
        // latch holds after the cause goes
        run(tbl[14], tbl[14][19:6]);
        run(tbl[14], 14'h000B);
        restart();
        run(tbl[0], tbl[0][19:6]);
        results();
    end
endmodule
bind status_led_indicator status_led_indicator_checker #(.LAMP_TEST(LAMP_TEST)) status_led_indicator_checker_i (
    .ref_clk, .reset, .device_error, .screen_error, .screen_warning, .sleep_mode, .identify_request,
    .safety_output_on, .field_interrupted, .interlocked, .report_screen_warning, .report_screen_error,
    .safety_output_indicator, .device_status_indicator);
`default_nettype wire

// ==== verilog/blink_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module blink_divider
    import status_led_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = 100
) (
    input wire logic ref_clk,
    input wire logic reset,
    output logic phase
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic next_phase;

    // Toggle phase every half period, giving an even square wave
    always_comb begin
        next_count = count + 32'h1;
        next_phase = phase;
        if (count >= CNT_W'(HALF_CYCLES - 1)) begin
            next_count = '0;
            next_phase = ~phase;
        end
    end

    // Counter and phase start together so both rates begin on the lit colour
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            phase <= 1'b0;
        end else begin
            count <= next_count;
            phase <= next_phase;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/status_led_indicator.sv ====
// Overview of operation
// - Output indicator green while safety output is on.
// - Output indicator red while safety output is off.
// - Status steady green only in verified normal or test mode without any condition.
// - Status steady yellow while active warning field is interrupted.
// - Status dark in sleep mode or with safety function stopped.
// - Identify request blinks status red and green alternately.
// - Device error blinks status red.
// - Recoverable error blinks status yellow at 3 Hz.
// - Unconfigured or faulty configuration blinks red and yellow alternately.
// - Unverified configuration blinks yellow and green alternately.
// - Running restart delay blinks status green at 3 Hz.
// - Contamination warning blinks status yellow at 1 Hz.
// - Test mode with unverified configuration blinks status green at 1 Hz.
// - Both indicators light briefly at power-up, then show status.
// - Front screen check gives warning (continue) or error (stop).
// - Contamination error forces safety output off, field interrupted.
// - Clean screen restores safety output on and field free.
// - Contamination warning and error are reported to machine control.
// - Indicator logic never influences the safety signalling path.
// - Recoverable error switches output off; restores automatically when gone.
// - Device error switches output off and latches until restart.
`timescale 1ns/1ps
`default_nettype none
module status_led_indicator
    import status_led_pkg::*;
#(
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYCLES,
    parameter int unsigned FAST_HALF = FAST_HALF_CYCLES,
    parameter int unsigned LAMP_TEST = LAMP_TEST_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic field_request_on,
    input wire logic configured,
    input wire logic config_fault,
    input wire logic config_verified,
    input wire logic test_mode,
    input wire logic device_error,
    input wire logic recoverable_error,
    input wire logic warning_field_interrupted,
    input wire logic restart_delay_active,
    input wire logic sleep_mode,
    input wire logic safety_stopped,
    input wire logic identify_request,
    input wire logic screen_warning,
    input wire logic screen_error,
    output logic safety_output_on,
    output logic field_interrupted,
    output logic interlocked,
    output logic report_screen_warning,
    output logic report_screen_error,
    output logic [1:0] safety_output_indicator,
    output logic [1:0] device_status_indicator
);
    typedef enum {ST_LAMP_TEST, ST_RUN} mode_t;

    // Two-flop synchronisers for all asynchronous status inputs
    localparam int N_IN = 14;
    logic [N_IN-1:0] in_raw;
    logic [N_IN-1:0] sync_a;
    logic [N_IN-1:0] sync_b;
    assign in_raw = {field_request_on, configured, config_fault, config_verified, test_mode,
                     device_error, recoverable_error, warning_field_interrupted,
                     restart_delay_active, sleep_mode, safety_stopped, identify_request,
                     screen_warning, screen_error};

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= in_raw;
            sync_b <= sync_a;
        end
    end

    logic s_field_on, s_configured, s_cfg_fault, s_verified, s_test, s_dev_err, s_rec_err;
    logic s_warn_field, s_restart, s_sleep, s_stopped, s_identify, s_scr_warn, s_scr_err;
    assign {s_field_on, s_configured, s_cfg_fault, s_verified, s_test, s_dev_err, s_rec_err,
            s_warn_field, s_restart, s_sleep, s_stopped, s_identify, s_scr_warn, s_scr_err}
           = sync_b;

    logic slow_phase;
    logic fast_phase;
    blink_divider #(.HALF_CYCLES(SLOW_HALF)) u_slow (
        .ref_clk(ref_clk),
        .reset(reset),
        .phase(slow_phase)
    );
    blink_divider #(.HALF_CYCLES(FAST_HALF)) u_fast (
        .ref_clk(ref_clk),
        .reset(reset),
        .phase(fast_phase)
    );

    // Safety path state: latched interlock and power-up timer
    logic next_interlocked;
    logic next_safety_output_on;
    logic next_field_interrupted;
    logic next_report_warn;
    logic next_report_err;
    mode_t mode;
    mode_t next_mode;
    logic [CNT_W-1:0] lamp_count;
    logic [CNT_W-1:0] next_lamp_count;
    logic any_stop;

    // safety path independent
    // Safety decisions read synchronised inputs, the interlock latch and the power-up mode, never indicator state
    always_comb begin
        next_interlocked = interlocked | s_dev_err;
        any_stop = next_interlocked | s_scr_err | s_rec_err | s_cfg_fault | ~s_configured
                   | s_stopped | s_sleep;
        next_safety_output_on = s_field_on & ~any_stop & (mode == ST_RUN);
        next_field_interrupted = ~next_safety_output_on;
        next_report_err = s_scr_err;
        next_report_warn = s_scr_warn & ~s_scr_err;
        next_mode = mode;
        next_lamp_count = lamp_count;
        case (mode)
            ST_LAMP_TEST: begin
                if (lamp_count >= CNT_W'(LAMP_TEST - 1)) begin
                    next_mode = ST_RUN;
                end else begin
                    next_lamp_count = lamp_count + 32'h1;
                end
            end
            ST_RUN: begin
                next_mode = ST_RUN;
            end
            default: begin
                next_mode = ST_LAMP_TEST;
            end
        endcase
    end

    // Reset leaves the output off and the field marked interrupted
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            interlocked <= 1'b0;
            safety_output_on <= 1'b0;
            field_interrupted <= 1'b1;
            report_screen_warning <= 1'b0;
            report_screen_error <= 1'b0;
            mode <= ST_LAMP_TEST;
            lamp_count <= '0;
        end else begin
            interlocked <= next_interlocked;
            safety_output_on <= next_safety_output_on;
            field_interrupted <= next_field_interrupted;
            report_screen_warning <= next_report_warn;
            report_screen_error <= next_report_err;
            mode <= next_mode;
            lamp_count <= next_lamp_count;
        end
    end

    // Conditions the status lamp can show, most severe first
    typedef enum {
        SHOW_IDENTIFY,
        SHOW_DEVICE_ERROR,
        SHOW_DARK,
        SHOW_CONFIG_FAULT,
        SHOW_RECOVERABLE,
        SHOW_TEST_MODE,
        SHOW_UNVERIFIED,
        SHOW_SCREEN_WARNING,
        SHOW_RESTART_DELAY,
        SHOW_WARNING_FIELD,
        SHOW_NORMAL
    } show_t;
    show_t show;
    logic [1:0] lit_color;
    logic [1:0] alt_color;
    logic use_fast;
    logic blink_phase;

    // severity order
    // Identify sits on top so an operator can always find the unit, even when faulted
    always_comb begin
        show = SHOW_NORMAL;
        if (s_identify) begin
            show = SHOW_IDENTIFY;
        end else if (interlocked) begin
            show = SHOW_DEVICE_ERROR;
        end else if (s_sleep | s_stopped) begin
            show = SHOW_DARK;
        end else if (~s_configured | s_cfg_fault) begin
            show = SHOW_CONFIG_FAULT;
        end else if (s_rec_err | s_scr_err) begin
            show = SHOW_RECOVERABLE;
        end else if (~s_verified & s_test) begin
            show = SHOW_TEST_MODE;
        end else if (~s_verified) begin
            show = SHOW_UNVERIFIED;
        end else if (s_scr_warn) begin
            show = SHOW_SCREEN_WARNING;
        end else if (s_restart) begin
            show = SHOW_RESTART_DELAY;
        end else if (s_warn_field) begin
            show = SHOW_WARNING_FIELD;
        end
    end

    // Each condition is a colour pair shown in turn; equal colours give a steady lamp
    always_comb begin
        lit_color = COLOR_GREEN;
        alt_color = COLOR_GREEN;
        use_fast = 1'b0;
        case (show)
            SHOW_IDENTIFY: begin
                lit_color = COLOR_RED;
                alt_color = COLOR_GREEN;
            end
            SHOW_DEVICE_ERROR: begin
                lit_color = COLOR_RED;
                alt_color = COLOR_OFF;
            end
            SHOW_DARK: begin
                lit_color = COLOR_OFF;
                alt_color = COLOR_OFF;
            end
            SHOW_CONFIG_FAULT: begin
                lit_color = COLOR_RED;
                alt_color = COLOR_YELLOW;
            end
            SHOW_RECOVERABLE: begin
                lit_color = COLOR_YELLOW;
                alt_color = COLOR_OFF;
                use_fast = 1'b1;
            end
            SHOW_TEST_MODE: begin
                lit_color = COLOR_GREEN;
                alt_color = COLOR_OFF;
            end
            SHOW_UNVERIFIED: begin
                lit_color = COLOR_YELLOW;
                alt_color = COLOR_GREEN;
            end
            SHOW_SCREEN_WARNING: begin
                lit_color = COLOR_YELLOW;
                alt_color = COLOR_OFF;
            end
            SHOW_RESTART_DELAY: begin
                lit_color = COLOR_GREEN;
                alt_color = COLOR_OFF;
                use_fast = 1'b1;
            end
            SHOW_WARNING_FIELD: begin
                lit_color = COLOR_YELLOW;
                alt_color = COLOR_YELLOW;
            end
            default: begin
                lit_color = COLOR_GREEN;
                alt_color = COLOR_GREEN;
            end
        endcase
    end

    // Indicator selection; reads safety state but never feeds back into it
    logic [1:0] next_out_led;
    logic [1:0] next_status_led;
    always_comb begin
        next_out_led = COLOR_RED;
        next_status_led = COLOR_OFF;
        blink_phase = use_fast ? fast_phase : slow_phase;
        if (mode == ST_LAMP_TEST) begin
            next_out_led = COLOR_YELLOW;
            next_status_led = COLOR_YELLOW;
        end else begin
            next_out_led = safety_output_on ? COLOR_GREEN : COLOR_RED;
            // Phase low shows the first colour of the pair
            next_status_led = blink_phase ? alt_color : lit_color;
        end
    end

    // Both lamps stay dark while reset is held
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            safety_output_indicator <= COLOR_OFF;
            device_status_indicator <= COLOR_OFF;
        end else begin
            safety_output_indicator <= next_out_led;
            device_status_indicator <= next_status_led;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/status_led_pkg.sv ====
`default_nettype none
package status_led_pkg;
    // System clock rate and blink rates
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SLOW_BLINK_HZ = 1;
    localparam int unsigned FAST_BLINK_HZ = 3;
    // Half periods give a 50 percent duty cycle
    localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / (2 * SLOW_BLINK_HZ);
    localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / (2 * FAST_BLINK_HZ);
    // Alternating two-colour patterns use the slow rate
    localparam int unsigned ALT_HALF_CYCLES = SLOW_HALF_CYCLES;
    // Power-up lamp test time in milliseconds
    localparam int unsigned LAMP_TEST_MS = 500;
    localparam int unsigned LAMP_TEST_CYCLES = (CLK_HZ / 1000) * LAMP_TEST_MS;
    localparam int unsigned CNT_W = 32;

    // Two-bit LED colour code: bit 0 green, bit 1 red, both lit is yellow
    typedef enum logic [1:0] {
        COLOR_OFF = 2'h0,
        COLOR_GREEN = 2'h1,
        COLOR_RED = 2'h2,
        COLOR_YELLOW = 2'h3
    } color_t;
endpackage
`default_nettype wire
